//--- hdl/hcpm_top.v
// command interpreter and power-save controller
//
// Behaviour
// - serial config accepts only the seven listed baud rates, then applies it
// - serial config rejects any character length other than eight bits
// - serial config selects even or odd parity and one or two stops
// - key command accepts only 10 or 26 hex digits, 64/128-bit key
// - host selects privacy none or WEP, and open or closed auth
// - channel command limited to 1..11, 1..13 or 1..14 by locale
// - power save command accepts modes 0, 1, 2, 5 only
// - commands set pin direction, drive outputs, sample inputs
// - join named network on command, leave it on another command
// - a command switches infrastructure and ad-hoc topology
// - queries return hardware address, signal level and locale
// - commands initialise a converter channel and read a conversion
// - mode 1 duty-cycles radio, controller awake and accepting commands
// - mode 2 enters standby when host drops sleep-permit line
// - mode 2 leaves standby on network packet or sleep-permit return
// - after start-up mode 5, radio powered down, awaiting commands
// - mode 5 accepts only serial config, power save, address, version
// - mode 1 is rejected as a bad argument while in ad-hoc topology
// - serial port comes up 115200 baud, eight bits, no parity, one stop
// - request-to-send held off after reset until ready for commands
`default_nettype none
`include "hcpm_regs.vh"
module hcpm_top #(
  parameter        NPIN    = 12,
  parameter        NCONV   = 2,
  parameter        CONV_W  = 10,
  parameter        NAME_W  = 8,
  parameter        ADDR_W  = 48,
  parameter        READY_CYC = 16,
  parameter [15:0] FW_VERSION = 16'h0100  // value is arbitrary
) (
  // clock and reset
  input  wire              mclk,
  input  wire              rst,
  input  wire              ce,
  // command request
  input  wire              cmd_valid,
  input  wire [4:0]        cmd_code,
  input  wire [7:0]        cmd_arg,
  input  wire [NPIN-1:0]   cmd_mask,
  input  wire [3:0]        key_digit,
  input  wire              key_digit_we,
  input  wire [NAME_W-1:0] cmd_name,
  // command answer
  output reg               rsp_valid,
  output reg  [1:0]        rsp_status,
  output reg  [ADDR_W-1:0] rsp_data,
  // host handshake pins
  output reg               rts_n,
  input  wire              sleep_permit,
  // serial port setting
  output reg  [2:0]        ser_baud,
  output reg               ser_par_en,
  output reg               ser_par_odd,
  output reg               ser_stop2,
  // network control and status
  input  wire              pkt_arrive,
  input  wire [ADDR_W-1:0] hw_addr,
  input  wire [7:0]        signal_level,
  output reg               radio_on,
  output reg               radio_ps,
  output reg               ctl_standby,
  output reg               adhoc,
  output reg  [3:0]        channel,
  output reg  [1:0]        locale,
  output reg               wep_on,
  output reg               auth_closed,
  output reg               key_128,
  output reg               join_req,
  output reg               leave_req,
  output reg               search_req,
  output reg  [NAME_W-1:0] net_name,
  output reg  [2:0]        ps_mode,
  // general-purpose pins
  input  wire [NPIN-1:0]   pin_i,
  output reg  [NPIN-1:0]   pin_o,
  output reg  [NPIN-1:0]   pin_oe,
  // converter
  output reg  [NCONV-1:0]  conv_en,
  output reg               conv_start,
  output reg  [7:0]        conv_sel,
  input  wire [CONV_W-1:0] conv_data
);
  localparam ST_BOOT  = 2'h0;
  localparam ST_READY = 2'h1;
  localparam ST_SLEEP = 2'h2;

  reg [1:0]  state_r;
  reg [7:0]  boot_cnt_r;
  reg [7:0]  key_cnt_r;
  reg [4:0]  key_wa_r;
  reg        sp_prev_r;
  wire [NPIN-1:0] pin_s;
  wire       sp_s;
  wire       pkt_s;
  wire [3:0] key_rd;
  reg        ok;
  reg        allowed;
  reg        bad;
  reg [3:0]  chan_max;

  // pins from outside pass the three-stage filter
  hcpm_sync #(.W(NPIN + 2)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .din  ({pin_i, sleep_permit, pkt_arrive}),
    .dout ({pin_s, sp_s, pkt_s})
  );

  hcpm_key_mem #(.DEPTH(26), .AW(5)) u_key (
    .mclk  (mclk),
    .ce    (ce),
    .we    (key_digit_we),
    .waddr (key_wa_r),
    .wdata (key_digit),
    .raddr (5'h00),
    .rdata (key_rd)
  );

  // channel ceiling follows the locale
  always @* begin
    case (locale)
      `HCPM_LOC_13: chan_max = `HCPM_CHAN_MAX_13;
      `HCPM_LOC_14: chan_max = `HCPM_CHAN_MAX_14;
      default:      chan_max = `HCPM_CHAN_MAX_11;
    endcase
  end

  // acceptance gate and argument check
  always @* begin
    allowed = (state_r == ST_READY);
    if (ps_mode == `HCPM_PS_5)
      allowed = allowed &&
        (cmd_code == `HCPM_CMD_SERIAL_CFG || cmd_code == `HCPM_CMD_PWR_SAVE ||
         cmd_code == `HCPM_CMD_HW_ADDR   || cmd_code == `HCPM_CMD_VERSION);
    bad = 1'b0;
    case (cmd_code)
      `HCPM_CMD_SERIAL_CFG:
        bad = (cmd_arg[`HCPM_SC_BAUD_MSB:0] > `HCPM_BAUD_921600) ||
              (cmd_arg[`HCPM_SC_LEN_MSB:`HCPM_SC_LEN_LSB] !=
               `HCPM_LEN_8BIT);
      `HCPM_CMD_KEY:
        bad = (key_cnt_r != `HCPM_KEY_DIGITS_64) &&
              (key_cnt_r != `HCPM_KEY_DIGITS_128);
      `HCPM_CMD_CHANNEL:
        bad = (cmd_arg[3:0] < `HCPM_CHAN_MIN) || (cmd_arg[3:0] > chan_max) ||
              (cmd_arg[7:4] != 4'h0);
      `HCPM_CMD_PWR_SAVE:
        bad = !(cmd_arg[2:0] == `HCPM_PS_0 || cmd_arg[2:0] == `HCPM_PS_1 ||
                cmd_arg[2:0] == `HCPM_PS_2 || cmd_arg[2:0] == `HCPM_PS_5) ||
              (cmd_arg[7:3] != 5'h00) ||
              (adhoc && cmd_arg[2:0] == `HCPM_PS_1);
      `HCPM_CMD_TOPOLOGY:
        bad = (ps_mode == `HCPM_PS_1) && cmd_arg[0];
      `HCPM_CMD_LOCALE_SET:
        bad = (cmd_arg[1:0] > `HCPM_LOC_14) || (cmd_arg[7:2] != 6'h00);
      `HCPM_CMD_CONV_INIT,
      `HCPM_CMD_CONV_READ:
        bad = (cmd_arg >= NCONV);
      default:
        bad = (cmd_code > `HCPM_CMD_VERSION);
    endcase
    ok = allowed && !bad;
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_r     <= ST_BOOT;
      boot_cnt_r  <= 8'h00;
      key_cnt_r   <= 8'h00;
      key_wa_r    <= 5'h00;
      sp_prev_r   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_status  <= `HCPM_ST_OK;
      rsp_data    <= {ADDR_W{1'b0}};
      rts_n       <= 1'b1;
      ser_baud    <= `HCPM_BAUD_115200;
      ser_par_en  <= 1'b0;
      ser_par_odd <= 1'b0;
      ser_stop2   <= 1'b0;
      radio_on    <= 1'b0;
      radio_ps    <= 1'b0;
      ctl_standby <= 1'b0;
      adhoc       <= 1'b0;
      channel     <= `HCPM_CHAN_MIN;
      locale      <= `HCPM_LOC_11;
      wep_on      <= 1'b0;
      auth_closed <= 1'b0;
      key_128     <= 1'b0;
      join_req    <= 1'b0;
      leave_req   <= 1'b0;
      search_req  <= 1'b0;
      net_name    <= {NAME_W{1'b0}};
      ps_mode     <= `HCPM_PS_5;
      pin_o       <= {NPIN{1'b0}};
      pin_oe      <= {NPIN{1'b0}};
      conv_en     <= {NCONV{1'b0}};
      conv_start  <= 1'b0;
      conv_sel    <= 8'h00;
    end else if (ce) begin
      rsp_valid  <= 1'b0;
      join_req   <= 1'b0;
      leave_req  <= 1'b0;
      search_req <= 1'b0;
      conv_start <= 1'b0;
      sp_prev_r  <= sp_s;
      if (key_digit_we) begin
        key_wa_r  <= key_wa_r + 5'h01;
        key_cnt_r <= key_cnt_r + 8'h01;
      end
      case (state_r)
        ST_BOOT: begin
          // hold off the host until the interpreter is settled
          if (boot_cnt_r == READY_CYC[7:0]) begin
            state_r <= ST_READY;
            rts_n   <= 1'b0;
          end else begin
            boot_cnt_r <= boot_cnt_r + 8'h01;
          end
        end
        ST_SLEEP: begin
          // standby wakes on a packet or on the permit coming back
          if (pkt_s || (sp_s && !sp_prev_r)) begin
            state_r     <= ST_READY;
            ctl_standby <= 1'b0;
            rts_n       <= 1'b0;
          end
        end
        ST_READY: begin
          if (ps_mode == `HCPM_PS_2 && sp_prev_r && !sp_s) begin
            state_r     <= ST_SLEEP;
            ctl_standby <= 1'b1;
            rts_n       <= 1'b1;
          end else if (cmd_valid) begin
            // mode 1 keeps the controller here, so commands stay served
            rsp_valid  <= 1'b1;
            rsp_status <= !allowed ? `HCPM_ST_REFUSED :
                          bad ? `HCPM_ST_BAD_ARG : `HCPM_ST_OK;
            rsp_data   <= {ADDR_W{1'b0}};
            if (ok) begin
              case (cmd_code)
                `HCPM_CMD_SERIAL_CFG: begin
                  ser_baud    <= cmd_arg[`HCPM_SC_BAUD_MSB:0];
                  ser_par_en  <= cmd_arg[`HCPM_SC_PAR_EN];
                  ser_par_odd <= cmd_arg[`HCPM_SC_PAR_ODD];
                  ser_stop2   <= cmd_arg[`HCPM_SC_STOP2];
                end
                `HCPM_CMD_WEP_SEL: wep_on <= cmd_arg[0];
                `HCPM_CMD_AUTH:    auth_closed <= cmd_arg[0];
                `HCPM_CMD_KEY: begin
                  key_128   <= (key_cnt_r == `HCPM_KEY_DIGITS_128);
                  key_cnt_r <= 8'h00;
                  key_wa_r  <= 5'h00;
                  rsp_data  <= {{(ADDR_W-4){1'b0}}, key_rd};
                end
                `HCPM_CMD_SEARCH:  search_req <= 1'b1;
                `HCPM_CMD_JOIN: begin
                  net_name <= cmd_name;
                  join_req <= 1'b1;
                end
                `HCPM_CMD_LEAVE:   leave_req <= 1'b1;
                `HCPM_CMD_TOPOLOGY: adhoc <= cmd_arg[0];
                `HCPM_CMD_CHANNEL: channel <= cmd_arg[3:0];
                `HCPM_CMD_HW_ADDR: rsp_data <= hw_addr;
                `HCPM_CMD_SIG_LEVEL:
                  rsp_data <= {{(ADDR_W-8){1'b0}}, signal_level};
                `HCPM_CMD_LOCALE_GET:
                  rsp_data <= {{(ADDR_W-2){1'b0}}, locale};
                `HCPM_CMD_LOCALE_SET: locale <= cmd_arg[1:0];
                `HCPM_CMD_PWR_SAVE: begin
                  ps_mode  <= cmd_arg[2:0];
                  radio_on <= (cmd_arg[2:0] != `HCPM_PS_5);
                  radio_ps <= (cmd_arg[2:0] == `HCPM_PS_1) ||
                              (cmd_arg[2:0] == `HCPM_PS_2);
                end
                `HCPM_CMD_CONV_INIT: begin
                  conv_en[cmd_arg[0]] <= 1'b1;
                end
                `HCPM_CMD_CONV_READ: begin
                  conv_sel   <= cmd_arg;
                  conv_start <= 1'b1;
                  rsp_data   <= {{(ADDR_W-CONV_W){1'b0}}, conv_data};
                end
                `HCPM_CMD_PIN_OUT: pin_oe <= pin_oe | cmd_mask;
                `HCPM_CMD_PIN_IN:  pin_oe <= pin_oe & ~cmd_mask;
                `HCPM_CMD_PIN_HIGH: pin_o <= pin_o | (cmd_mask & pin_oe);
                `HCPM_CMD_PIN_LOW:  pin_o <= pin_o & ~(cmd_mask & pin_oe);
                `HCPM_CMD_PIN_SAMPLE:
                  rsp_data <= {{(ADDR_W-NPIN){1'b0}},
                               pin_s & cmd_mask & ~pin_oe};
                `HCPM_CMD_VERSION:
                  rsp_data <= {{(ADDR_W-16){1'b0}}, FW_VERSION};
                default: rsp_data <= {ADDR_W{1'b0}};
              endcase
            end
          end
        end
        default: state_r <= ST_BOOT;
      endcase
    end
  end
endmodule // hcpm_top
`default_nettype wire

//--- common/hcpm_regs.vh
// constants for the host command power manager
`ifndef HCPM_REGS_VH
`define HCPM_REGS_VH
// command codes
`define HCPM_CMD_SERIAL_CFG   5'h00
`define HCPM_CMD_WEP_SEL      5'h01
`define HCPM_CMD_KEY          5'h02
`define HCPM_CMD_AUTH         5'h03
`define HCPM_CMD_SEARCH       5'h04
`define HCPM_CMD_JOIN         5'h05
`define HCPM_CMD_LEAVE        5'h06
`define HCPM_CMD_TOPOLOGY     5'h07
`define HCPM_CMD_CHANNEL      5'h08
`define HCPM_CMD_HW_ADDR      5'h09
`define HCPM_CMD_PWR_SAVE     5'h0a
`define HCPM_CMD_SIG_LEVEL    5'h0b
`define HCPM_CMD_LOCALE_GET   5'h0c
`define HCPM_CMD_LOCALE_SET   5'h0d
`define HCPM_CMD_CONV_INIT    5'h0e
`define HCPM_CMD_CONV_READ    5'h0f
`define HCPM_CMD_PIN_OUT      5'h10
`define HCPM_CMD_PIN_IN       5'h11
`define HCPM_CMD_PIN_HIGH     5'h12
`define HCPM_CMD_PIN_LOW      5'h13
`define HCPM_CMD_PIN_SAMPLE   5'h14
`define HCPM_CMD_VERSION      5'h15
// baud codes
`define HCPM_BAUD_9600        3'h0
`define HCPM_BAUD_19200       3'h1
`define HCPM_BAUD_38400       3'h2
`define HCPM_BAUD_57600       3'h3
`define HCPM_BAUD_115200      3'h4
`define HCPM_BAUD_230400      3'h5
`define HCPM_BAUD_921600      3'h6
// serial config arg layout: [2:0] baud, [4:3] length, [5] parity on,
// [6] parity odd, [7] two stop bits
`define HCPM_SC_BAUD_MSB      2
`define HCPM_SC_LEN_MSB       4
`define HCPM_SC_LEN_LSB       3
`define HCPM_SC_PAR_EN        5
`define HCPM_SC_PAR_ODD       6
`define HCPM_SC_STOP2         7
`define HCPM_LEN_8BIT         2'h3
// key lengths in hex digits
`define HCPM_KEY_DIGITS_64    8'h0a
`define HCPM_KEY_DIGITS_128   8'h1a
// power save modes
`define HCPM_PS_0             3'h0
`define HCPM_PS_1             3'h1
`define HCPM_PS_2             3'h2
`define HCPM_PS_5             3'h5
// locale codes and channel limits
`define HCPM_LOC_11           2'h0
`define HCPM_LOC_13           2'h1
`define HCPM_LOC_14           2'h2
`define HCPM_CHAN_MIN         4'h1
`define HCPM_CHAN_MAX_11      4'hb
`define HCPM_CHAN_MAX_13      4'hd
`define HCPM_CHAN_MAX_14      4'he
// answer status
`define HCPM_ST_OK            2'h0
`define HCPM_ST_REFUSED       2'h1
`define HCPM_ST_BAD_ARG       2'h2
`endif

//--- hdl/hcpm_sync.v
// three-stage synchroniser with agreement on the last two stages
`default_nettype none
module hcpm_sync #(
  parameter        W = 1
) (
  // clock and control
  input  wire         mclk,
  input  wire         rst,
  input  wire         ce,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar g;
  always @(posedge mclk) begin
    if (rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a bit only moves once two later stages agree, filtering single glitches
  generate
    for (g = 0; g < W; g = g + 1) begin : g_agree
      always @(posedge mclk) begin
        if (rst)
          dout[g] <= 1'b0;
        else if (ce && (s2_r[g] == s3_r[g]))
          dout[g] <= s3_r[g];
      end
    end
  endgenerate
endmodule // hcpm_sync
`default_nettype wire

//--- hdl/hcpm_key_mem.v
// small memory holding the privacy key digits, registered read
`default_nettype none
module hcpm_key_mem #(
  parameter        DEPTH = 26,
  parameter        AW    = 5
) (
  // clock
  input  wire          mclk,
  input  wire          ce,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [3:0]    wdata,
  // read port
  input  wire [AW-1:0] raddr,
  output reg  [3:0]    rdata
);
  reg [3:0] mem [0:DEPTH-1];
  always @(posedge mclk) begin
    if (ce) begin
      if (we)
        mem[waddr] <= wdata;
      rdata <= mem[raddr];
    end
  end
endmodule // hcpm_key_mem
`default_nettype wire

//--- verif/hcpm_sva.sv
// checker for the command interpreter and power-save controller
`default_nettype none
module hcpm_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  // command and answer
  input wire logic       cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic       rsp_valid,
  input wire logic [1:0] rsp_status,
  input wire logic       rts_n,
  // settings and state
  input wire logic [2:0] ser_baud,
  input wire logic       ser_par_en,
  input wire logic       ser_stop2,
  input wire logic       sleep_permit,
  input wire logic       radio_on,
  input wire logic       radio_ps,
  input wire logic       ctl_standby,
  input wire logic       adhoc,
  input wire logic [2:0] ps_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    cmd_valid && ce && !rts_n;
  endsequence
  sequence s_ps(m);
    s_take ##0 (cmd_code == 5'h0a && cmd_arg == m);
  endsequence
  property p_boot;
    $fell(rst) |-> rts_n && ps_mode == 3'h5 && !radio_on && ser_baud == 3'h4
      && !ser_par_en && !ser_stop2;
  endproperty
  a_boot: assert property (p_boot) else $error("bad state after reset");
  property p_rts_hold;
    $fell(rst) |-> rts_n [*8];
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("rts_n low too soon");
  property p_answer;
    s_take |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_refuse5;
    s_take ##0 (ps_mode == 3'h5 &&
      !(cmd_code inside {5'h00, 5'h09, 5'h0a, 5'h15})) |=> rsp_status == 2'h1;
  endproperty
  a_refuse5: assert property (p_refuse5) else $error("mode 5 not refused");
  property p_ser_bad;
    s_take ##0 (cmd_code == 5'h00 &&
      (cmd_arg[2:0] == 3'h7 || cmd_arg[4:3] != 2'h3))
      |=> rsp_status == 2'h2 && $stable(ser_baud);
  endproperty
  a_ser_bad: assert property (p_ser_bad) else $error("bad serial taken");
  property p_ser_ok;
    s_take ##0 (cmd_code == 5'h00 && cmd_arg[2:0] != 3'h7 &&
      cmd_arg[4:3] == 2'h3) |=> rsp_status == 2'h0 &&
      ser_baud == $past(cmd_arg[2:0]) && ser_stop2 == $past(cmd_arg[7]);
  endproperty
  a_ser_ok: assert property (p_ser_ok) else $error("serial not applied");
  property p_ps_bad;
    s_take ##0 (cmd_code == 5'h0a && !(cmd_arg inside {0, 1, 2, 5}))
      |=> rsp_status == 2'h2 && $stable(ps_mode);
  endproperty
  a_ps_bad: assert property (p_ps_bad) else $error("bad mode taken");
  property p_ps1;
    s_ps(8'h01) ##0 !adhoc |=> ps_mode == 3'h1 && radio_on && radio_ps;
  endproperty
  a_ps1: assert property (p_ps1) else $error("mode 1 not entered");
  property p_ps1_adhoc;
    s_ps(8'h01) ##0 adhoc |=> rsp_status == 2'h2 && $stable(ps_mode);
  endproperty
  a_ps1_adhoc: assert property (p_ps1_adhoc) else $error("mode 1 in ad-hoc");
  property p_standby;
    disable iff (rst || !ce)
    ps_mode == 3'h2 && !ctl_standby && $fell(sleep_permit)
      |-> ##[1:8] (ctl_standby && rts_n);
  endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  property p_wake;
    ctl_standby && $rose(sleep_permit) |-> ##[1:8] (!ctl_standby && !rts_n);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule // hcpm_sva
`default_nettype wire

//--- verif/hcpm_host_model.sv
// host model: sends commands after the ready handshake, drives sleep lines
`default_nettype none
module hcpm_host_model #(
  parameter NPIN = 12
) (
  // clock and answer
  input  wire logic            mclk,
  input  wire logic            rts_n,
  input  wire logic            rsp_valid,
  input  wire logic [1:0]      rsp_status,
  // command request
  output var  logic            cmd_valid,
  output var  logic [4:0]      cmd_code,
  output var  logic [7:0]      cmd_arg,
  output var  logic [NPIN-1:0] cmd_mask,
  output var  logic [3:0]      key_digit,
  output var  logic            key_digit_we,
  // sleep control
  output var  logic            sleep_permit,
  output var  logic            pkt_arrive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 5'h1f;
    cmd_arg = 8'h00;
    cmd_mask = '0;
    key_digit = 4'h0;
    key_digit_we = 1'b0;
    sleep_permit = 1'b1;
    pkt_arrive = 1'b0;
  end
  // idle lines are inverted so a late latch sees garbage, not stale data
  task automatic cmd(input logic [4:0] c, input logic [7:0] a,
                     input logic [NPIN-1:0] m, output logic [1:0] s);
    int n;
    n = 0;
    s = 2'h3;
    // an idle edge first keeps back-to-back calls from re-raising valid
    do begin
      @(negedge mclk);
      n++;
    end while (rts_n !== 1'b0 && n < 200);
    if (rts_n === 1'b0) begin
      cmd_code = c;
      cmd_arg = a;
      cmd_mask = m;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_arg = ~a;
      cmd_mask = ~m;
      if (rsp_valid === 1'b1) s = rsp_status;
    end
  endtask
  task automatic keys(input int k);
    for (int i = 0; i < k; i++) begin
      key_digit = 4'(i);
      key_digit_we = 1'b1;
      @(negedge mclk);
    end
    key_digit_we = 1'b0;
  endtask
  task automatic permit(input logic v);
    sleep_permit = v;
  endtask
endmodule // hcpm_host_model
`default_nettype wire

//--- verif/hcpm_top_tb.sv
// self-checking testbench for the command and power-save controller
`default_nettype none
`include "hcpm_regs.vh"
bind hcpm_top hcpm_sva u_sva (.mclk(mclk), .rst(rst), .ce(ce),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
  .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rts_n(rts_n),
  .ser_baud(ser_baud), .ser_par_en(ser_par_en), .ser_stop2(ser_stop2),
  .sleep_permit(sleep_permit), .radio_on(radio_on), .radio_ps(radio_ps),
  .ctl_standby(ctl_standby), .adhoc(adhoc), .ps_mode(ps_mode));
module hcpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, cmd_valid, key_digit_we, sleep_permit, pkt_arrive;
  logic        rsp_valid, rts_n, ce;
  logic [4:0]  cmd_code, cfg;
  logic [7:0]  cmd_arg, signal_level, a, name_v;
  logic [11:0] cmd_mask, pin_i, mask;
  logic [3:0]  key_digit;
  logic [1:0]  rsp_status, e;
  logic [47:0] hw_addr;
  logic [9:0]  conv_data;
  int          seed = 55157;
  int          fails = 0;
  int          checks = 0;
  int          n;
  int          kn[4] = '{10, 26, 11, 25};
  hcpm_top #(.READY_CYC(16)) uut (.mclk(mclk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .cmd_mask(cmd_mask), .key_digit(key_digit), .key_digit_we(key_digit_we),
    .cmd_name(name_v), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_data(), .rts_n(rts_n), .sleep_permit(sleep_permit),
    .ser_baud(), .ser_par_en(), .ser_par_odd(), .ser_stop2(),
    .pkt_arrive(pkt_arrive), .hw_addr(hw_addr), .signal_level(signal_level),
    .radio_on(), .radio_ps(), .ctl_standby(), .adhoc(), .channel(),
    .locale(), .wep_on(), .auth_closed(), .key_128(), .join_req(),
    .leave_req(), .search_req(), .net_name(), .ps_mode(), .pin_i(pin_i),
    .pin_o(), .pin_oe(), .conv_en(), .conv_start(), .conv_sel(),
    .conv_data(conv_data));
  hcpm_host_model host (.mclk(mclk), .rts_n(rts_n), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .cmd_mask(cmd_mask), .key_digit(key_digit),
    .key_digit_we(key_digit_we), .sleep_permit(sleep_permit),
    .pkt_arrive(pkt_arrive));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] ex,
                     input logic [47:0] got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic go(input logic [4:0] c, input logic [7:0] v,
                    input logic [1:0] ex);
    logic [1:0] s;
    host.cmd(c, v, mask, s);
    chk("status", 48'(ex), 48'(s));
    if (s === 2'h3) give_verdict;
  endtask
  task automatic wt(input logic v);
    int k;
    k = 0;
    while (uut.ctl_standby !== v && k < 20) begin
      @(negedge mclk);
      k++;
    end
    chk("standby", 48'(v), 48'(uut.ctl_standby));
    if (k == 20) give_verdict;
  endtask
  function automatic logic [1:0] ser_exp(input logic [7:0] v);
    return (v[2:0] <= `HCPM_BAUD_921600 && v[4:3] == `HCPM_LEN_8BIT)
      ? `HCPM_ST_OK : `HCPM_ST_BAD_ARG;
  endfunction
  function automatic logic [1:0] chan_exp(input int loc, input int ch);
    int mx;
    mx = (loc == 0) ? 11 : (loc == 1) ? 13 : 14;
    return (ch >= 1 && ch <= mx) ? `HCPM_ST_OK : `HCPM_ST_BAD_ARG;
  endfunction
  // a hang anywhere still ends in the closing report
  initial begin
    #3000000;
    fails++;
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    name_v = 8'($random(seed));
    hw_addr = {16'($random(seed)), 32'($random(seed))};
    signal_level = 8'($random(seed));
    pin_i = 12'($random(seed));
    conv_data = 10'($random(seed));
    mask = 12'h000;
    repeat (20) @(negedge mclk);
    chk("rts_n", 1, rts_n);
    chk("baud", `HCPM_BAUD_115200, uut.ser_baud);
    chk("par_stop", 0, {uut.ser_par_en, uut.ser_stop2});
    chk("ps_mode", `HCPM_PS_5, uut.ps_mode);
    chk("radio_on", 0, uut.radio_on);
    rst = 1'b0;
    n = 0;
    while (rts_n !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("ready_wait", 1, n >= 17 && n <= 18);
    if (n == 100) give_verdict;
    done("reset");
    for (int c = 1; c <= 'h15; c++) begin
      e = (c == 'h09 || c == 'h15) ? `HCPM_ST_OK : `HCPM_ST_REFUSED;
      if (c != 'h0a) go(5'(c), 8'h01, e);
      if (c == 'h09) chk("hw_addr", hw_addr, uut.rsp_data);
    end
    chk("ps_mode", `HCPM_PS_5, uut.ps_mode);
    cfg = 5'h10;
    // first eight cover every baud code, the unused one included
    for (int i = 0; i < 24; i++) begin
      a = 8'($random(seed));
      if (i < 8) a = {a[7:5], `HCPM_LEN_8BIT, 3'(i)};
      e = ser_exp(a);
      go(`HCPM_CMD_SERIAL_CFG, a, e);
      if (e == `HCPM_ST_OK) cfg = {a[2:0], a[5], a[7]};
      chk("ser", cfg, {uut.ser_baud, uut.ser_par_en, uut.ser_stop2});
      if (e == `HCPM_ST_OK && a[5]) chk("odd", a[6], uut.ser_par_odd);
    end
    done("serial");
    for (int m = 3; m < 8; m++) begin
      if (m != 5) go(`HCPM_CMD_PWR_SAVE, 8'(m), `HCPM_ST_BAD_ARG);
    end
    chk("ps_mode", `HCPM_PS_5, uut.ps_mode);
    go(`HCPM_CMD_PWR_SAVE, 8'h01, `HCPM_ST_OK);
    chk("ps1", 7, {uut.ps_mode == `HCPM_PS_1, uut.radio_on, uut.radio_ps});
    go(`HCPM_CMD_WEP_SEL, 8'h01, `HCPM_ST_OK);
    go(`HCPM_CMD_AUTH, 8'h01, `HCPM_ST_OK);
    chk("wep_auth", 3, {uut.wep_on, uut.auth_closed});
    go(`HCPM_CMD_TOPOLOGY, 8'h01, `HCPM_ST_BAD_ARG);
    go(`HCPM_CMD_PWR_SAVE, 8'h00, `HCPM_ST_OK);
    go(`HCPM_CMD_TOPOLOGY, 8'h01, `HCPM_ST_OK);
    chk("adhoc", 1, uut.adhoc);
    go(`HCPM_CMD_PWR_SAVE, 8'h01, `HCPM_ST_BAD_ARG);
    chk("ps_mode", `HCPM_PS_0, uut.ps_mode);
    done("power_save");
    for (int loc = 0; loc < 4; loc++) begin
      e = (loc < 3) ? `HCPM_ST_OK : `HCPM_ST_BAD_ARG;
      go(`HCPM_CMD_LOCALE_SET, 8'(loc), e);
      for (int ch = 0; ch < 16 && loc < 3; ch++) begin
        e = chan_exp(loc, ch);
        go(`HCPM_CMD_CHANNEL, 8'(ch), e);
        if (e == `HCPM_ST_OK) chk("channel", ch, uut.channel);
      end
    end
    go(`HCPM_CMD_LOCALE_GET, 8'h00, `HCPM_ST_OK);
    chk("locale", `HCPM_LOC_14, uut.rsp_data);
    go(`HCPM_CMD_TOPOLOGY, 8'h00, `HCPM_ST_OK);
    go(`HCPM_CMD_SIG_LEVEL, 8'h00, `HCPM_ST_OK);
    chk("sig_level", signal_level, uut.rsp_data[7:0]);
    go(`HCPM_CMD_JOIN, 8'h00, `HCPM_ST_OK);
    chk("join", {1'b1, name_v}, {uut.join_req, uut.net_name});
    go(`HCPM_CMD_LEAVE, 8'h00, `HCPM_ST_OK);
    done("network");
    foreach (kn[i]) begin
      host.keys(kn[i]);
      e = (kn[i] == 10 || kn[i] == 26) ? `HCPM_ST_OK : `HCPM_ST_BAD_ARG;
      go(`HCPM_CMD_KEY, 8'h00, e);
      if (e == `HCPM_ST_OK) chk("key_128", kn[i] == 26, uut.key_128);
    end
    mask = 12'($random(seed));
    go(`HCPM_CMD_PIN_OUT, 8'h00, `HCPM_ST_OK);
    chk("pin_oe", mask, uut.pin_oe);
    go(`HCPM_CMD_PIN_HIGH, 8'h00, `HCPM_ST_OK);
    chk("pin_o", mask, uut.pin_o & mask);
    go(`HCPM_CMD_PIN_IN, 8'h00, `HCPM_ST_OK);
    go(`HCPM_CMD_PIN_SAMPLE, 8'h00, `HCPM_ST_OK);
    chk("pin_in", pin_i & mask, uut.rsp_data);
    go(`HCPM_CMD_CONV_INIT, 8'h02, `HCPM_ST_BAD_ARG);
    go(`HCPM_CMD_CONV_INIT, 8'h01, `HCPM_ST_OK);
    go(`HCPM_CMD_CONV_READ, 8'h01, `HCPM_ST_OK);
    chk("conv", conv_data, uut.rsp_data[9:0]);
    done("keys_pins_conv");
    go(`HCPM_CMD_PWR_SAVE, 8'h02, `HCPM_ST_OK);
    host.permit(1'b0);
    wt(1'b1);
    chk("rts_sleep", 1, rts_n);
    host.permit(1'b1);
    wt(1'b0);
    chk("rts_wake", 0, rts_n);
    host.permit(1'b0);
    ce = 1'b0;
    repeat (10) @(negedge mclk);
    chk("freeze", 0, uut.ctl_standby);
    ce = 1'b1;
    wt(1'b1);
    host.pkt_arrive = 1'b1;
    repeat (2) @(negedge mclk);
    host.pkt_arrive = 1'b0;
    wt(1'b0);
    done("mode2");
    give_verdict;
  end
endmodule // hcpm_top_tb
`default_nettype wire
